// ### dv/testbench.sv
// Purpose: table-driven check of the watchpoint comparators
// Assumes: ack one cycle after a request is taken, watch outputs one cycle late
// Notes: each row is one watched cycle followed by an idle cycle
`include "wpc_cfg.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [15:0] f; logic [31:0] l1; logic [31:0] l2;} wpc_tcfg_s;
  typedef struct packed {
    logic [3:0]  k;
    logic [11:0] fa;
    logic        w;
    logic [1:0]  sz;
    logic [7:0]  la;
    logic [31:0] ld;
    logic [9:0]  e;
  } wpc_trow_s;

  logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, ls_addr, ls_data, rd;
  logic [3:0]  wb_sel_i, fetch_watch, ldst_data_event;
  logic        ifetch_valid, ls_valid, ls_write;
  logic [29:0] ifetch_addr;
  logic [1:0]  ls_size, ldst_watch;
  logic [9:0]  got;
  int          failures, cmp_count;

  // G lane 3 holds 7 for greater-or-equal 8, masks leave lane 3 only in byte mode
  wpc_tcfg_s cfg [14] = '{'{16'h0000, 32'h0, 32'h0}, '{16'h0001, 32'h0, 32'h0},
    '{16'h0200, 32'h0, 32'h0}, '{16'h010B, 32'h0, 32'h0}, '{16'h08E0, 32'h0, 32'h0},
    '{16'h04B0, 32'h0, 32'h0}, '{16'h0000, 32'h00EE_00B0, 32'h0},
    '{16'h0000, 32'h00EE_00B0, 32'h0040_00C8}, '{16'h0000, 32'h05EE_00B0, 32'h0040_00C8},
    '{16'h0000, 32'h00EF_00BB, 32'h0020_0018}, '{16'h0000, 32'h00EE_00B0, 32'h0001_0010},
    '{16'h0000, 32'h0000_14B0, 32'h00C0_0100}, '{16'h0000, 32'h0000_15B0, 32'h0},
    '{16'h0000, 32'h0000_28B0, 32'h0}};

  wpc_trow_s rows [29] = '{
    '{4'h0, 12'h040, 1'b0, 2'h3, 8'h00, 32'h0, 10'h040},
    '{4'h1, 12'h040, 1'b0, 2'h3, 8'h00, 32'h0, 10'h000},
    '{4'h1, 12'h041, 1'b0, 2'h3, 8'h00, 32'h0, 10'h040},
    '{4'h2, 12'h040, 1'b0, 2'h3, 8'h00, 32'h0, 10'h0C0},
    '{4'h3, 12'h050, 1'b0, 2'h3, 8'h00, 32'h0, 10'h0C0},
    '{4'h3, 12'h090, 1'b0, 2'h3, 8'h00, 32'h0, 10'h000},
    '{4'h4, 12'h050, 1'b0, 2'h3, 8'h00, 32'h0, 10'h300},
    '{4'h4, 12'h110, 1'b0, 2'h3, 8'h00, 32'h0, 10'h200},
    '{4'h5, 12'h0D0, 1'b0, 2'h3, 8'h00, 32'h0, 10'h300},
    '{4'h5, 12'h050, 1'b0, 2'h3, 8'h00, 32'h0, 10'h200},
    '{4'h6, 12'h000, 1'b0, 2'h0, 8'h03, 32'h0000_0009, 10'h03F},
    '{4'h7, 12'h000, 1'b0, 2'h0, 8'h03, 32'h0000_000D, 10'h029},
    '{4'h7, 12'h000, 1'b0, 2'h0, 8'h03, 32'h0000_0007, 10'h00A},
    '{4'h7, 12'h000, 1'b0, 2'h2, 8'h00, 32'h1234_5609, 10'h03F},
    '{4'h7, 12'h000, 1'b0, 2'h1, 8'h02, 32'h0000_0009, 10'h03F},
    '{4'h7, 12'h000, 1'b0, 2'h0, 8'h02, 32'h0000_0900, 10'h000},
    '{4'h8, 12'h000, 1'b0, 2'h0, 8'h03, 32'h0000_0009, 10'h02F},
    '{4'h8, 12'h000, 1'b1, 2'h0, 8'h03, 32'h0000_0009, 10'h03F},
    '{4'h9, 12'h000, 1'b0, 2'h0, 8'h08, 32'h0, 10'h030},
    '{4'h9, 12'h000, 1'b0, 2'h0, 8'h20, 32'h0, 10'h020},
    '{4'hA, 12'h040, 1'b0, 2'h0, 8'h0C, 32'h0, 10'h070},
    '{4'hA, 12'h041, 1'b0, 2'h0, 8'h0D, 32'h0, 10'h000},
    '{4'hB, 12'h000, 1'b0, 2'h2, 8'h00, 32'hA000_0000, 10'h01B},
    '{4'hB, 12'h000, 1'b0, 2'h0, 8'h00, 32'h5000_0000, 10'h000},
    '{4'hB, 12'h000, 1'b0, 2'h1, 8'h00, 32'h5000_0000, 10'h03F},
    '{4'hB, 12'h000, 1'b0, 2'h1, 8'h00, 32'h0000_5000, 10'h01A},
    '{4'hC, 12'h000, 1'b0, 2'h2, 8'h00, 32'hA000_0000, 10'h03A},
    '{4'hD, 12'h000, 1'b0, 2'h2, 8'h00, 32'h5000_0000, 10'h03F},
    '{4'hD, 12'h000, 1'b0, 2'h0, 8'h00, 32'h5000_0000, 10'h030}};

  wpc_core_model core (.sys_clk(sys_clk), .ifetch_valid(ifetch_valid),
    .ifetch_addr(ifetch_addr), .ls_valid(ls_valid), .ls_write(ls_write),
    .ls_size(ls_size), .ls_addr(ls_addr), .ls_data(ls_data));

  wpc_top DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ifetch_valid(ifetch_valid),
    .ifetch_addr(ifetch_addr), .ls_valid(ls_valid), .ls_write(ls_write),
    .ls_size(ls_size), .ls_addr(ls_addr), .ls_data(ls_data), .fetch_watch(fetch_watch),
    .ldst_watch(ldst_watch), .ldst_data_event(ldst_data_event));

  task automatic final_report;
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_watch(input string n, input logic [9:0] e, input logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // ack is read before the edge's own update lands, as the slave saw it
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, 4'hF, x);
  endtask

  // got holds the result of the cycle launched by the previous call
  task automatic run(input logic fv, input logic [29:0] fa, input logic lv, input logic w,
                     input logic [1:0] sz, input logic [31:0] la, input logic [31:0] ld);
    core.step(fv, fa, lv, w, sz, la, ld);
    #1;
    got = {fetch_watch, ldst_watch, ldst_data_event};
  endtask

  task automatic idle;
    run(1'b0, 30'h0, 1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    final_report();
  end

  initial begin
    failures  = 0;
    cmp_count = 0;
    rst      <= 1'b1;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_adr_i <= 32'h0;
    wb_sel_i <= 4'h0;
    wb_dat_i <= 32'h0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    wr(`WPC_OFS_FC0, 32'h0000_0100);
    wr(`WPC_OFS_FC1, 32'h0000_0200);
    wr(`WPC_OFS_FC2, 32'h0000_0300);
    wr(`WPC_OFS_FC3, 32'h0000_0400);
    wr(`WPC_OFS_LA0, 32'h0000_0003);
    wr(`WPC_OFS_LA1, 32'h0000_000C);
    wr(`WPC_OFS_LD0, 32'h4E20_0007);
    wr(`WPC_OFS_LD1, 32'h9C40_000C);
    for (int i = 0; i < 29; i++) begin
      if (i == 0 || rows[i].k != rows[i-1].k) begin
        wr(`WPC_OFS_FCTL, {16'h0000, cfg[rows[i].k].f});
        wr(`WPC_OFS_LC1, cfg[rows[i].k].l1);
        wr(`WPC_OFS_LC2, cfg[rows[i].k].l2);
      end
      run(rows[i].fa != 12'h000, {18'h0, rows[i].fa}, rows[i].sz != 2'h3, rows[i].w,
          rows[i].sz, {24'h0, rows[i].la}, rows[i].ld);
      idle();
      chk_watch("table row", rows[i].e, got);
    end
    run(1'b1, 30'h40, 1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
    run(1'b1, 30'h80, 1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
    chk_watch("first of two fetches", 10'h040, got);
    idle();
    chk_watch("second of two fetches", 10'h080, got);
    wb(1'b0, `WPC_OFS_FC1, 32'h0, 4'hF, rd);
    chk_reg("compare 1 readback", 32'h0000_0200, rd);
    wb(1'b0, 32'h0000_0030, 32'h0, 4'hF, rd);
    chk_reg("unmapped read", 32'h0, rd);
    wb(1'b0, 32'h0000_0110, 32'h0, 4'hF, rd);
    chk_reg("high address read", 32'h0, rd);
    wb(1'b1, `WPC_OFS_STAT, 32'hFFFF_FFFF, 4'hF, rd);
    wb(1'b0, `WPC_OFS_STAT, 32'h0, 4'hF, rd);
    chk_reg("status after write", 32'h0, rd);
    // a hit driven inside reset must not show
    @(posedge sys_clk);
    rst <= 1'b1;
    run(1'b1, 30'h40, 1'b1, 1'b0, 2'h0, 32'h3, 32'h9);
    idle();
    chk_watch("during reset", 10'h000, got);
    @(posedge sys_clk);
    rst <= 1'b0;
    wb(1'b0, `WPC_OFS_FC0, 32'h0, 4'hF, rd);
    chk_reg("compare 0 after reset", 32'h0, rd);
    run(1'b1, 30'h0, 1'b1, 1'b0, 2'h0, 32'h0, 32'h0);
    idle();
    chk_watch("zero config", 10'h3FF, got);
    wb(1'b1, `WPC_OFS_LD0, 32'hAABB_CCDD, 4'h5, rd);
    wb(1'b0, `WPC_OFS_LD0, 32'h0, 4'hF, rd);
    chk_reg("byte enables", 32'h00BB_00DD, rd);
    final_report();
  end
endmodule

// ### dv/wpc_core_model.sv
// Purpose: core side of the watch inputs, fetch and load/store cycles
// Assumes: one access per cycle, launched right after a rising edge
// Notes: idle lines show the inverse of the last value, never a held copy
module wpc_core_model (
  input  wire logic        sys_clk,
  output logic             ifetch_valid,
  output logic      [29:0] ifetch_addr,
  output logic             ls_valid,
  output logic             ls_write,
  output logic      [1:0]  ls_size,
  output logic      [31:0] ls_addr,
  output logic      [31:0] ls_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ifetch_valid = 1'b0;
    ifetch_addr  = 30'h0;
    ls_valid     = 1'b0;
    ls_write     = 1'b0;
    ls_size      = 2'h0;
    ls_addr      = 32'h0;
    ls_data      = 32'h0;
  end

  // one cycle per call; a stale address must not pass for a fresh one
  task automatic step(input logic fv, input logic [29:0] fa, input logic lv,
                      input logic w, input logic [1:0] sz, input logic [31:0] la,
                      input logic [31:0] ld);
    @(posedge sys_clk);
    ifetch_valid <= fv;
    ifetch_addr  <= fv ? fa : ~ifetch_addr;
    ls_valid     <= lv;
    ls_write     <= lv ? w : ~ls_write;
    ls_size      <= lv ? sz : ~ls_size;
    ls_addr      <= lv ? la : ~ls_addr;
    ls_data      <= lv ? ld : ~ls_data;
  endtask
endmodule

// ### rtl/wpc_cfg.svh
// Purpose: constants for the watchpoint comparator block
// Assumes: 32-bit classic wishbone register port
// Notes: big-endian lanes, lane 0 is data[31:24]
`ifndef WPC_CFG_SVH
`define WPC_CFG_SVH
`define WPC_OFS_FC0  32'h0000_0000
`define WPC_OFS_FC1  32'h0000_0004
`define WPC_OFS_FC2  32'h0000_0008
`define WPC_OFS_FC3  32'h0000_000C
`define WPC_OFS_LA0  32'h0000_0010
`define WPC_OFS_LA1  32'h0000_0014
`define WPC_OFS_LD0  32'h0000_0018
`define WPC_OFS_LD1  32'h0000_001C
`define WPC_OFS_FCTL 32'h0000_0020
`define WPC_OFS_LC1  32'h0000_0024
`define WPC_OFS_LC2  32'h0000_0028
`define WPC_OFS_STAT 32'h0000_002C
// fetch control: type per comparator, pairing bit per watch
`define WPC_ITYP(i)  2*(i)+:2
`define WPC_ICOMB(i) 8+(i)
// control 1: types E,F,G,H; sign, size and mask of G,H; read/write match of E,F
`define WPC_LTYP(i)  2*(i)+:2
`define WPC_LSGN(i)  8+(i)
`define WPC_LSIZ(i)  10+2*(i)+:2
`define WPC_LMSK(i)  16+4*(i)+:4
`define WPC_LRWV(i)  24+(i)
`define WPC_LRWC(i)  26+(i)
// control 2: selectors of load/store watch w
`define WPC_WIW(w)   16*(w)+:3
`define WPC_WADR(w)  16*(w)+3+:3
`define WPC_WDAT(w)  16*(w)+6+:3
`define WPC_SEL_DC   3'h0
`define WPC_SEL_A    3'h1
`define WPC_SEL_B    3'h2
`define WPC_SEL_AND  3'h3
`define WPC_SEL_OR   3'h4
`define WPC_SEL_IWN  3'h4
`define WPC_SZ_BYTE  2'h0
`define WPC_SZ_HALF  2'h1
`define WPC_SZ_WORD  2'h2
`define WPC_AM_WORD  32'hFFFF_FFFC
`define WPC_AM_HALF  32'hFFFF_FFFE
`define WPC_AM_BYTE  32'hFFFF_FFFF
`define WPC_ZERO32   32'h0000_0000
`define WPC_UPPER_Z  24'h00_0000
`endif

// ### rtl/wpc_pkg.sv
// Purpose: types for the watchpoint comparator block
// Assumes: nothing beyond the cfg header
// Notes: state is one packed struct
package wpc_pkg;
  typedef enum logic [1:0] {
    WPC_CMP_EQ = 2'h0,
    WPC_CMP_NE = 2'h1,
    WPC_CMP_GT = 2'h3,
    WPC_CMP_LT = 2'h2
  } wpc_cmp_e;

  typedef struct packed {
    logic [3:0][31:0] fcmp;
    logic [1:0][31:0] lacmp;
    logic [1:0][31:0] ldcmp;
    logic [31:0]      fctl;
    logic [31:0]      lctl1;
    logic [31:0]      lctl2;
    logic             ack;
    logic [31:0]      rdat;
    logic [3:0]       fw;
    logic [1:0]       lw;
    logic [3:0]       dev;
  } wpc_state_s;
endpackage

// ### rtl/wpc_top.sv
// Purpose: fetch and load/store watchpoint comparators
// Assumes: bus inputs synchronous to sys_clk, one cycle per access
// Notes: outputs are registered, one cycle after the access
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`include "wpc_cfg.svh"

module wpc_top
  import wpc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ifetch_valid,
  input  wire logic [29:0] ifetch_addr,
  input  wire logic        ls_valid,
  input  wire logic        ls_write,
  input  wire logic [1:0]  ls_size,
  input  wire logic [31:0] ls_addr,
  input  wire logic [31:0] ls_data,
  output logic      [3:0]  fetch_watch,
  output logic      [1:0]  ldst_watch,
  output logic      [3:0]  ldst_data_event
);

  wpc_state_s s_r;
  wpc_state_s s_nxt;

  function automatic logic cmp_ev(
    input logic [1:0] t,
    input logic       eq,
    input logic       lt
  );
    case (wpc_cmp_e'(t))
      WPC_CMP_EQ: cmp_ev = eq;
      WPC_CMP_NE: cmp_ev = !eq;
      WPC_CMP_GT: cmp_ev = !eq && !lt;
      default:    cmp_ev = lt;
    endcase
  endfunction

  // unknown selector codes never fire; data pairs pass the per-lane and/or events
  function automatic logic pick_pair(
    input logic [2:0] sel,
    input logic       a,
    input logic       b,
    input logic       a_and_b,
    input logic       a_or_b
  );
    case (sel)
      `WPC_SEL_DC:  pick_pair = 1'b1;
      `WPC_SEL_A:   pick_pair = a;
      `WPC_SEL_B:   pick_pair = b;
      `WPC_SEL_AND: pick_pair = a_and_b;
      `WPC_SEL_OR:  pick_pair = a_or_b;
      default:      pick_pair = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge_be(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  sel
  );
    merge_be = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge_be[8*b+:8] = nw[8*b+:8];
      end
    end
  endfunction

  // fetch side
  logic [3:0] ieq;
  logic [3:0] ilt;
  logic [3:0] iev;
  logic [3:0] iw;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_fetch
      assign ieq[gi] = ifetch_addr == s_r.fcmp[gi][31:2];
      assign ilt[gi] = ifetch_addr < s_r.fcmp[gi][31:2];
      assign iev[gi] = ifetch_valid &
                       cmp_ev(s_r.fctl[`WPC_ITYP(gi)], ieq[gi], ilt[gi]);
    end
    for (gi = 0; gi < 2; gi++) begin : g_fpair
      // and-pair for in range, or-pair for out of range
      assign iw[2*gi] = s_r.fctl[`WPC_ICOMB(2*gi)] ?
                        (iev[2*gi] & iev[2*gi+1]) : iev[2*gi];
      assign iw[2*gi+1] = s_r.fctl[`WPC_ICOMB(2*gi+1)] ?
                          (iev[2*gi] | iev[2*gi+1]) : iev[2*gi+1];
    end
  endgenerate

  // load/store address side
  logic [31:0] amask;
  logic [1:0]  lev;

  always_comb begin
    case (ls_size)
      `WPC_SZ_WORD: amask = `WPC_AM_WORD;
      `WPC_SZ_HALF: amask = `WPC_AM_HALF;
      default:      amask = `WPC_AM_BYTE;
    endcase
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_laddr
      logic am_eq;
      logic am_lt;
      logic rw_ok;
      // aligned boundaries only; unaligned ranges may misfire
      assign am_eq = (ls_addr & amask) == (s_r.lacmp[gi] & amask);
      assign am_lt = (ls_addr & amask) < (s_r.lacmp[gi] & amask);
      assign rw_ok = !s_r.lctl1[`WPC_LRWC(gi)] ||
                     (ls_write == s_r.lctl1[`WPC_LRWV(gi)]);
      assign lev[gi] = ls_valid & rw_ok &
                       cmp_ev(s_r.lctl1[`WPC_LTYP(gi)], am_eq, am_lt);
    end
  endgenerate

  // byte lanes valid for this cycle
  logic [3:0] bvalid;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bval
      localparam logic [1:0] LANE = 2'(gi);
      assign bvalid[gi] = ls_valid &&
        ((ls_size == `WPC_SZ_WORD) ||
         (ls_size == `WPC_SZ_HALF && ls_addr[1] == LANE[1]) ||
         (ls_size == `WPC_SZ_BYTE && ls_addr[1:0] == LANE));
    end
  endgenerate

  // load/store data side
  logic [1:0][3:0] dmatch;

  genvar gd;
  genvar gl;
  generate
    for (gd = 0; gd < 2; gd++) begin : g_data
      logic [1:0] siz;
      logic       sgn;
      logic [3:0] act;
      logic [3:0] msk;
      logic [3:0] beq;
      logic [3:0] blt;
      logic       weq;
      logic       wlt;
      assign siz = s_r.lctl1[`WPC_LSIZ(gd)];
      assign sgn = s_r.lctl1[`WPC_LSGN(gd)];
      assign msk = s_r.lctl1[`WPC_LMSK(gd)];
      for (gl = 0; gl < 4; gl++) begin : g_lane
        localparam int HB = (gl / 2) * 2;
        logic [7:0] bd;
        logic [7:0] bc;
        logic       top;
        logic       heq;
        logic       hlt;
        assign bd = ls_data[31-8*gl-:8];
        assign bc = s_r.ldcmp[gd][31-8*gl-:8];
        assign act[gl] = !msk[3-gl];
        // sign only matters in the top byte of the merged group
        assign top = (siz == `WPC_SZ_BYTE) || (gl == HB && siz == `WPC_SZ_HALF) ||
                     (gl == 0);
        assign beq[gl] = act[gl] && (bd == bc);
        assign blt[gl] = act[gl] && ((top && sgn) ? ($signed(bd) < $signed(bc))
                                                  : (bd < bc));
        assign heq = beq[HB] & beq[HB+1];
        assign hlt = blt[HB] | (beq[HB] & blt[HB+1]);
        always_comb begin
          case (siz)
            `WPC_SZ_BYTE: dmatch[gd][gl] = bvalid[gl] & act[gl] &
              cmp_ev(s_r.lctl1[`WPC_LTYP(gd+2)], beq[gl], blt[gl]);
            `WPC_SZ_HALF: dmatch[gd][gl] = (&bvalid[HB+:2]) & (&act[HB+:2]) &
              cmp_ev(s_r.lctl1[`WPC_LTYP(gd+2)], heq, hlt);
            `WPC_SZ_WORD: dmatch[gd][gl] = (&bvalid) & (&act) &
              cmp_ev(s_r.lctl1[`WPC_LTYP(gd+2)], weq, wlt);
            default:      dmatch[gd][gl] = 1'b0;
          endcase
        end
      end
      assign weq = &beq;
      assign wlt = blt[0] | (beq[0] & (blt[1] | (beq[1] & (blt[2] |
                   (beq[2] & blt[3])))));
    end
  endgenerate

  logic [3:0] dev;
  assign dev[0] = |dmatch[0];
  assign dev[1] = |dmatch[1];
  assign dev[2] = |(dmatch[0] & dmatch[1]);
  assign dev[3] = |(dmatch[0] | dmatch[1]);

  // load/store watches
  logic [1:0] lw;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lw
      logic [2:0] isel;
      logic       iok;
      assign isel = s_r.lctl2[`WPC_WIW(gi)];
      // qualifier is the fetch watch of the same cycle
      assign iok = (isel == `WPC_SEL_DC) ||
                   (isel <= `WPC_SEL_IWN && iw[2'(isel - 3'h1)]);
      assign lw[gi] = ls_valid & iok &
                      pick_pair(s_r.lctl2[`WPC_WADR(gi)], lev[0], lev[1], lev[0] & lev[1],
                                lev[0] | lev[1]) &
                      pick_pair(s_r.lctl2[`WPC_WDAT(gi)], dev[0], dev[1], dev[2],
                                dev[3]);
    end
  endgenerate

  logic bus_req;
  logic upper_ok;
  assign bus_req = wb_cyc_i & wb_stb_i & !s_r.ack;
  assign upper_ok = wb_adr_i[31:8] == `WPC_UPPER_Z;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = bus_req;
    s_nxt.rdat = `WPC_ZERO32;
    s_nxt.fw = iw;
    s_nxt.lw = lw;
    s_nxt.dev = dev;
    if (bus_req && !wb_we_i && upper_ok) begin
      case (wb_adr_i)
        `WPC_OFS_FC0:  s_nxt.rdat = s_r.fcmp[0];
        `WPC_OFS_FC1:  s_nxt.rdat = s_r.fcmp[1];
        `WPC_OFS_FC2:  s_nxt.rdat = s_r.fcmp[2];
        `WPC_OFS_FC3:  s_nxt.rdat = s_r.fcmp[3];
        `WPC_OFS_LA0:  s_nxt.rdat = s_r.lacmp[0];
        `WPC_OFS_LA1:  s_nxt.rdat = s_r.lacmp[1];
        `WPC_OFS_LD0:  s_nxt.rdat = s_r.ldcmp[0];
        `WPC_OFS_LD1:  s_nxt.rdat = s_r.ldcmp[1];
        `WPC_OFS_FCTL: s_nxt.rdat = s_r.fctl;
        `WPC_OFS_LC1:  s_nxt.rdat = s_r.lctl1;
        `WPC_OFS_LC2:  s_nxt.rdat = s_r.lctl2;
        `WPC_OFS_STAT: s_nxt.rdat = {22'h00_0000, s_r.fw, s_r.lw, s_r.dev};
        default:       s_nxt.rdat = `WPC_ZERO32;
      endcase
    end
    if (bus_req && wb_we_i && upper_ok) begin
      case (wb_adr_i)
        `WPC_OFS_FC0:  s_nxt.fcmp[0] = merge_be(s_r.fcmp[0], wb_dat_i, wb_sel_i);
        `WPC_OFS_FC1:  s_nxt.fcmp[1] = merge_be(s_r.fcmp[1], wb_dat_i, wb_sel_i);
        `WPC_OFS_FC2:  s_nxt.fcmp[2] = merge_be(s_r.fcmp[2], wb_dat_i, wb_sel_i);
        `WPC_OFS_FC3:  s_nxt.fcmp[3] = merge_be(s_r.fcmp[3], wb_dat_i, wb_sel_i);
        `WPC_OFS_LA0:  s_nxt.lacmp[0] = merge_be(s_r.lacmp[0], wb_dat_i, wb_sel_i);
        `WPC_OFS_LA1:  s_nxt.lacmp[1] = merge_be(s_r.lacmp[1], wb_dat_i, wb_sel_i);
        `WPC_OFS_LD0:  s_nxt.ldcmp[0] = merge_be(s_r.ldcmp[0], wb_dat_i, wb_sel_i);
        `WPC_OFS_LD1:  s_nxt.ldcmp[1] = merge_be(s_r.ldcmp[1], wb_dat_i, wb_sel_i);
        `WPC_OFS_FCTL: s_nxt.fctl = merge_be(s_r.fctl, wb_dat_i, wb_sel_i);
        `WPC_OFS_LC1:  s_nxt.lctl1 = merge_be(s_r.lctl1, wb_dat_i, wb_sel_i);
        `WPC_OFS_LC2:  s_nxt.lctl2 = merge_be(s_r.lctl2, wb_dat_i, wb_sel_i);
        default:       s_nxt.rdat = `WPC_ZERO32;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign fetch_watch = s_r.fw;
  assign ldst_watch = s_r.lw;
  assign ldst_data_event = s_r.dev;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_fetch_eq;
    ifetch_valid && ifetch_addr == s_r.fcmp[0][31:2] && !s_r.fctl[`WPC_ICOMB(0)] &&
    s_r.fctl[`WPC_ITYP(0)] == WPC_CMP_EQ |=> fetch_watch[0];
  endproperty
  a_fetch_eq: assert property (p_fetch_eq) else $error("fetch equal missed");

  property p_fetch_gt;
    ifetch_valid && ifetch_addr <= s_r.fcmp[3][31:2] &&
    s_r.fctl[`WPC_ITYP(3)] == WPC_CMP_GT |-> !iev[3];
  endproperty
  a_fetch_gt: assert property (p_fetch_gt) else $error("fetch gt false hit");

  property p_fetch_or;
    fetch_watch[1] && $past(s_r.fctl[`WPC_ICOMB(1)]) |->
      $past(iev[0]) || $past(iev[1]);
  endproperty
  a_fetch_or: assert property (p_fetch_or) else $error("or pair without cause");

  property p_fetch_and;
    fetch_watch[0] && $past(s_r.fctl[`WPC_ICOMB(0)]) |-> $past(ifetch_valid) &&
      $past(iev[1]);
  endproperty
  a_fetch_and: assert property (p_fetch_and) else $error("and pair bad");

  property p_word_mask;
    ls_valid && ls_size == `WPC_SZ_WORD && ls_addr[31:2] == s_r.lacmp[0][31:2] &&
    s_r.lctl1[`WPC_LTYP(0)] == WPC_CMP_EQ && !s_r.lctl1[`WPC_LRWC(0)] |=> 
      $past(lev[0]);
  endproperty
  a_word_mask: assert property (p_word_mask) else $error("low bits not ignored");

  property p_small_cycle;
    ls_size == `WPC_SZ_BYTE && s_r.lctl1[`WPC_LSIZ(0)] == `WPC_SZ_WORD
      |=> !ldst_data_event[0];
  endproperty
  a_small_cycle: assert property (p_small_cycle) else $error("small cycle matched");

  property p_idle_data;
    !ls_valid |=> ldst_data_event == 4'h0 && ldst_watch == 2'h0;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("event without cycle");

  property p_all_masked;
    s_r.lctl1[`WPC_LMSK(0)] == 4'hF |=> !ldst_data_event[0];
  endproperty
  a_all_masked: assert property (p_all_masked) else $error("masked lane matched");

  property p_ev_and;
    ldst_data_event[2] |-> ldst_data_event[0] && ldst_data_event[1];
  endproperty
  a_ev_and: assert property (p_ev_and) else $error("g and h event bad");

  property p_ev_or;
    ldst_data_event[3] == (ldst_data_event[0] || ldst_data_event[1]);
  endproperty
  a_ev_or: assert property (p_ev_or) else $error("g or h event bad");

  property p_dont_care;
    ls_valid && s_r.lctl2[15:0] == 16'h0000 |=> ldst_watch[0];
  endproperty
  a_dont_care: assert property (p_dont_care) else $error("dont care not true");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

  c_fetch_hit: cover property (fetch_watch[0]);
  c_ldst_hit: cover property (ldst_watch[1]);
  c_data_both: cover property (ldst_data_event[2]);
  c_bus_write: cover property (wb_ack_o && $past(wb_we_i));

endmodule
